// ==== shared/wdfe_pkg.sv ====
// Constants and types of the waveform dead-time and fault extension.
// Assumes a 32-bit AXI4-Lite register bus, one register per aligned word.
package wdfe_pkg;

   // ***************************************************************
   // Register indexes, byte address is four times the index
   // ***************************************************************
   localparam logic [5:0] IDX_CTRL = 6'h00;
   localparam logic [5:0] IDX_FMASK = 6'h02;
   localparam logic [5:0] IDX_FCTRL = 6'h03;
   localparam logic [5:0] IDX_STATUS = 6'h04;
   localparam logic [5:0] IDX_BOTH = 6'h06;
   localparam logic [5:0] IDX_BOTH_BUF = 6'h07;
   localparam logic [5:0] IDX_DT_LOW = 6'h08;
   localparam logic [5:0] IDX_DT_HIGH = 6'h09;
   localparam logic [5:0] IDX_DT_LOW_BUF = 6'h0a;
   localparam logic [5:0] IDX_DT_HIGH_BUF = 6'h0b;
   localparam logic [5:0] IDX_OVEN = 6'h0c;

   // ***************************************************************
   // Field positions and reset values
   // ***************************************************************
   localparam int STAT_LOW_VALID = 0;
   localparam int STAT_HIGH_VALID = 1;
   localparam int STAT_FAULT_FLAG = 2;
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_CLEAR_OVERRIDE = 2'h1;
   localparam logic [1:0] ACT_UNDEFINED = 2'h2;
   localparam logic [1:0] ACT_TRISTATE = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ***************************************************************
   // Register layouts and carriers
   // ***************************************************************
   typedef struct packed {
      logic [1:0] reserved;
      logic pattern_mode;
      logic common_waveform_mode;
      logic [3:0] channel_dead_time_enable;
   } wdfe_ctrl_s;

   typedef struct packed {
      logic [2:0] reserved_hi;
      logic ignore_debug_break;
      logic reserved_lo;
      logic fault_restart_mode;
      logic [1:0] fault_action;
   } wdfe_fctrl_s;

   // Timer side: waveforms, its own pin drive, update and lock
   typedef struct packed {
      logic [3:0] wg;
      logic [7:0] tc_out;
      logic update;
      logic lock_update_flag;
   } wdfe_tc_s;

   // Port side: output and direction registers of the pin port
   typedef struct packed {
      logic [7:0] port_out;
      logic [7:0] port_dir;
   } wdfe_port_s;

   typedef enum logic {FS_NORMAL, FS_FAULT} wdfe_fstate_e;

endpackage : wdfe_pkg

// ==== hdl/wdfe_top.sv ====
// Dead-time insertion, pattern mode, pin override and fault protection.
// Assumes timer, port, event and debug inputs come from logic on clk.
//
// How it works
// - Pattern mode bypasses dead time; dead-time registers hold the pattern.
// - Common waveform mode feeds channel A waveform to all four generators.
// - Per-channel enable lets its dead-time generator replace the timer waveform.
// - Masked event channels are ORed into one fault source.
// - A detected fault performs the currently selected fault action.
// - Fault flag sets on a fault, clears only by writing one.
// - Debug break is a fault unless the ignore bit is set.
// - Restart mode bit selects latched (0) or cycle-by-cycle (1).
// - Latched: leave fault after fault ends and flag cleared, at UPDATE.
// - Cycle-by-cycle: leave fault at first UPDATE after fault ends.
// - Action 00 none, 01 clears override enables, 11 tri-states enabled pairs, or the low-buffer pins in pattern mode.
// - Status bits 1 and 0 show valid buffers; no transfer when clear.
// - Lock-update flag from the timer blocks buffer transfer.
// - Both-sides write loads high and low dead time at once.
// - Both-sides buffer write loads both buffers at once.
// - Low-side register holds the low dead time in clock cycles.
// - High-side register holds the high dead time in clock cycles.
// - Valid buffer contents move to active registers on UPDATE.
// - Override enable bit per pin overrides port output, not direction.
// - Override enables accept writes only while the fault flag is zero.
// - Reserved status bits read as zero.
// - Each generator has an 8-bit counter decrementing to zero.
// - Non-zero counter forces both outputs of the pair off.
// - Rising edge reloads from low dead time, falling from high.
// - Fault restore uses the timer's own update event.
`timescale 1ns/1ps
`default_nettype none

module wdfe_top
   import wdfe_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int CHANNELS = 4
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire wdfe_tc_s tc,
   input wire wdfe_port_s port,
   input wire logic [7:0] fault_events,
   input wire logic debug_break,
   output logic [7:0] pin_out,
   output logic [7:0] pin_dir,
   output logic fault_active
);

   // ***************************************************************
   // Helpers
   // ***************************************************************
   // Channel enables to pin pairs: channel c owns pins 2c and 2c+1
   function automatic logic [7:0] pair_mask(input logic [3:0] ch);
      logic [7:0] m;
      m = 8'h00;
      for (int c = 0; c < 4; c++) begin
         m[2*c] = ch[c];
         m[2*c+1] = ch[c];
      end
      return m;
   endfunction : pair_mask

   function automatic logic is_mapped(input logic [5:0] idx);
      return (idx == IDX_CTRL) || (idx == IDX_FMASK) || (idx == IDX_FCTRL) ||
         (idx == IDX_STATUS) || (idx == IDX_BOTH) || (idx == IDX_BOTH_BUF) ||
         ((idx >= IDX_DT_LOW) && (idx <= IDX_OVEN));
   endfunction : is_mapped

   // ***************************************************************
   // Register state
   // ***************************************************************
   wdfe_ctrl_s ctrl_q;
   wdfe_fctrl_s fctrl_q;
   logic [7:0] fault_event_mask_bits_q;
   logic fault_flag_q;
   logic low_buffer_valid_q;
   logic high_buffer_valid_q;
   logic [7:0] dt_low_q;
   logic [7:0] high_side_delay_q;
   logic [7:0] low_side_delay_buffer_q;
   logic [7:0] high_side_delay_buffer_q;
   logic [7:0] pin_override_enables_q;
   logic [7:0] dir_clear_q;
   wdfe_fstate_e fstate_q;

   // ***************************************************************
   // AXI4-Lite write channel
   // ***************************************************************
   logic aw_have_q;
   logic w_have_q;
   logic [5:0] wr_idx_q;
   logic [7:0] wr_data_q;
   logic wr_lane_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic wr_go;
   logic wr_en;

   // Address and data may arrive in either order; both wait until the answer drains
   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready = !w_have_q && !bvalid_q;
   assign wr_go = aw_have_q && w_have_q;
   assign wr_en = wr_go && wr_lane_q && is_mapped(wr_idx_q);
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // Capture of address, data and the write answer
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         wr_idx_q <= 6'h00;
         wr_data_q <= 8'h00;
         wr_lane_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            wr_idx_q <= s_axi_awaddr[7:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wr_data_q <= s_axi_wdata[7:0];
            wr_lane_q <= s_axi_wstrb[0];
         end
         if (wr_go) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(wr_idx_q) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   function automatic logic wr_hit(input logic [5:0] a, input logic [5:0] b);
      return a == b;
   endfunction : wr_hit

   // ***************************************************************
   // Fault detection
   // ***************************************************************
   logic fault_src;
   logic fault_det;
   logic prot_on;
   logic restore;
   logic flag_clear;

   // Code 10 is undefined and is read as protection off
   assign prot_on = (fctrl_q.fault_action != ACT_NONE) && (fctrl_q.fault_action != ACT_UNDEFINED);
   assign fault_src = (|(fault_events & fault_event_mask_bits_q)) ||
      (debug_break && !fctrl_q.ignore_debug_break);
   assign fault_det = prot_on && fault_src;
   assign flag_clear = wr_en && wr_hit(wr_idx_q, IDX_STATUS) && wr_data_q[STAT_FAULT_FLAG];
   // Leave fault only on the timer's update, never between updates
   assign restore = (fstate_q == FS_FAULT) && !fault_det && tc.update &&
      (fctrl_q.fault_restart_mode || !fault_flag_q);
   assign fault_active = (fstate_q == FS_FAULT);

   // Fault state machine
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fstate_q <= FS_NORMAL;
      end else begin
         case (fstate_q)
            FS_NORMAL: begin
               if (fault_det) begin
                  fstate_q <= FS_FAULT;
               end
            end
            FS_FAULT: begin
               if (restore) begin
                  fstate_q <= FS_NORMAL;
               end
            end
            default: begin
               fstate_q <= FS_NORMAL;
            end
         endcase
      end
   end

   // Fault flag: a new fault wins over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fault_flag_q <= 1'b0;
      end else if (fault_det) begin
         fault_flag_q <= 1'b1;
      end else if (flag_clear) begin
         fault_flag_q <= 1'b0;
      end
   end

   // Direction clear: pairs of enabled channels, or the low buffer in pattern mode
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dir_clear_q <= 8'h00;
      end else if (fault_det && (fctrl_q.fault_action == ACT_TRISTATE)) begin
         dir_clear_q <= ctrl_q.pattern_mode ? low_side_delay_buffer_q :
            pair_mask(ctrl_q.channel_dead_time_enable);
      end else if (restore) begin
         dir_clear_q <= 8'h00;
      end
   end

   // ***************************************************************
   // Control registers
   // ***************************************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_q <= RST_REG;
         fctrl_q <= RST_REG;
         fault_event_mask_bits_q <= RST_REG;
      end else if (wr_en) begin
         if (wr_hit(wr_idx_q, IDX_CTRL)) begin
            ctrl_q <= wr_data_q;
         end
         if (wr_hit(wr_idx_q, IDX_FCTRL)) begin
            fctrl_q <= wr_data_q;
         end
         if (wr_hit(wr_idx_q, IDX_FMASK)) begin
            fault_event_mask_bits_q <= wr_data_q;
         end
      end
   end

   // ***************************************************************
   // Dead-time registers and double buffering
   // ***************************************************************
   logic xfer_low;
   logic xfer_high;
   logic wr_low_buf;
   logic wr_high_buf;

   assign xfer_low = tc.update && !tc.lock_update_flag && low_buffer_valid_q;
   assign xfer_high = tc.update && !tc.lock_update_flag && high_buffer_valid_q;
   assign wr_low_buf = wr_en && (wr_hit(wr_idx_q, IDX_DT_LOW_BUF) || wr_hit(wr_idx_q, IDX_BOTH_BUF));
   assign wr_high_buf = wr_en && (wr_hit(wr_idx_q, IDX_DT_HIGH_BUF) || wr_hit(wr_idx_q, IDX_BOTH_BUF));

   // Active low-side and high-side delays; a direct write wins over a transfer
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dt_low_q <= RST_REG;
         high_side_delay_q <= RST_REG;
      end else begin
         if (wr_en && (wr_hit(wr_idx_q, IDX_DT_LOW) || wr_hit(wr_idx_q, IDX_BOTH))) begin
            dt_low_q <= wr_data_q;
         end else if (xfer_low) begin
            dt_low_q <= low_side_delay_buffer_q;
         end
         if (wr_en && (wr_hit(wr_idx_q, IDX_DT_HIGH) || wr_hit(wr_idx_q, IDX_BOTH))) begin
            high_side_delay_q <= wr_data_q;
         end else if (xfer_high) begin
            high_side_delay_q <= high_side_delay_buffer_q;
         end
      end
   end

   // Buffers and their valid flags; a fresh write keeps the flag set
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         low_side_delay_buffer_q <= RST_REG;
         high_side_delay_buffer_q <= RST_REG;
         low_buffer_valid_q <= 1'b0;
         high_buffer_valid_q <= 1'b0;
      end else begin
         if (wr_low_buf) begin
            low_side_delay_buffer_q <= wr_data_q;
            low_buffer_valid_q <= 1'b1;
         end else if (xfer_low) begin
            low_buffer_valid_q <= 1'b0;
         end
         if (wr_high_buf) begin
            high_side_delay_buffer_q <= wr_data_q;
            high_buffer_valid_q <= 1'b1;
         end else if (xfer_high) begin
            high_buffer_valid_q <= 1'b0;
         end
      end
   end

   // Override enables: under action 01 fault clears them, restore reloads them; writes need a clear flag
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_override_enables_q <= RST_REG;
      end else if (fault_det && (fctrl_q.fault_action == ACT_CLEAR_OVERRIDE)) begin
         pin_override_enables_q <= 8'h00;
      end else if (restore && (fctrl_q.fault_action == ACT_CLEAR_OVERRIDE)) begin
         pin_override_enables_q <= ctrl_q.pattern_mode ? low_side_delay_buffer_q :
            pair_mask(ctrl_q.channel_dead_time_enable);
      end else if (wr_en && wr_hit(wr_idx_q, IDX_OVEN) && !fault_flag_q) begin
         pin_override_enables_q <= wr_data_q;
      end else if (ctrl_q.pattern_mode && xfer_low && !fault_flag_q) begin
         pin_override_enables_q <= low_side_delay_buffer_q;
      end
   end

   // ***************************************************************
   // AXI4-Lite read channel
   // ***************************************************************
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic [7:0] rd_val;
   logic [5:0] rd_idx;

   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign rd_idx = s_axi_araddr[7:2];

   // Read mux; write-only locations and reserved status bits read as zero
   always_comb begin
      rd_val = 8'h00;
      case (rd_idx)
         IDX_CTRL: rd_val = ctrl_q;
         IDX_FMASK: rd_val = fault_event_mask_bits_q;
         IDX_FCTRL: rd_val = fctrl_q;
         IDX_STATUS: rd_val = {5'h00, fault_flag_q, high_buffer_valid_q, low_buffer_valid_q};
         IDX_DT_LOW: rd_val = dt_low_q;
         IDX_DT_HIGH: rd_val = high_side_delay_q;
         IDX_DT_LOW_BUF: rd_val = low_side_delay_buffer_q;
         IDX_DT_HIGH_BUF: rd_val = high_side_delay_buffer_q;
         IDX_OVEN: rd_val = pin_override_enables_q;
         default: rd_val = 8'h00;
      endcase
   end

   // One read under way; the answer stands until rready
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rdata_q <= {24'h00_0000, rd_val};
         rresp_q <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ***************************************************************
   // Dead-time generators
   // ***************************************************************
   logic [CHANNELS-1:0] wg_sel;
   logic [CHANNELS-1:0] wg_prev_q;
   logic [7:0] dt_cnt_q [CHANNELS];
   logic [7:0] dt_pins;

   // Common mode uses the channel A waveform for every generator
   always_comb begin
      for (int c = 0; c < CHANNELS; c++) begin
         wg_sel[c] = ctrl_q.common_waveform_mode ? tc.wg[0] : tc.wg[c];
      end
   end

   // Counter reloads on each waveform edge, else counts down to zero
   always_ff @(posedge clk) begin
      for (int c = 0; c < CHANNELS; c++) begin
         if (sys_rst) begin
            wg_prev_q[c] <= 1'b0;
            dt_cnt_q[c] <= 8'h00;
         end else begin
            wg_prev_q[c] <= wg_sel[c];
            if (wg_sel[c] && !wg_prev_q[c]) begin
               dt_cnt_q[c] <= dt_low_q;
            end else if (!wg_sel[c] && wg_prev_q[c]) begin
               dt_cnt_q[c] <= high_side_delay_q;
            end else if (dt_cnt_q[c] != 8'h00) begin
               dt_cnt_q[c] <= dt_cnt_q[c] - 8'h01;
            end
         end
      end
   end

   // Low side follows the waveform, high side its inverse, both off while counting
   always_comb begin
      for (int c = 0; c < CHANNELS; c++) begin
         dt_pins[2*c] = wg_prev_q[c] && (dt_cnt_q[c] == 8'h00);
         dt_pins[2*c+1] = !wg_prev_q[c] && (dt_cnt_q[c] == 8'h00);
      end
   end

   // ***************************************************************
   // Pin drive
   // ***************************************************************
   logic [7:0] pin_out_q;
   logic [7:0] pin_dir_q;
   logic [7:0] dt_owned;

   assign dt_owned = pair_mask(ctrl_q.channel_dead_time_enable);
   assign pin_out = pin_out_q;
   assign pin_dir = pin_dir_q;

   // Registered pin mux; direction only ever gated by the tri-state action
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_out_q <= 8'h00;
         pin_dir_q <= 8'h00;
      end else begin
         for (int p = 0; p < 8; p++) begin
            if (ctrl_q.pattern_mode) begin
               pin_out_q[p] <= pin_override_enables_q[p] ? tc.wg[0] : high_side_delay_q[p];
            end else if (dt_owned[p]) begin
               pin_out_q[p] <= pin_override_enables_q[p] ? dt_pins[p] : port.port_out[p];
            end else begin
               pin_out_q[p] <= tc.tc_out[p];
            end
         end
         pin_dir_q <= port.port_dir & ~dir_clear_q;
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   AST_PATTERN_PIN: assert property (@(posedge clk) disable iff (sys_rst)
      (ctrl_q.pattern_mode && pin_override_enables_q[0]) |=> (pin_out[0] == $past(tc.wg[0])))
      else $error("Pattern mode pin does not follow channel A");
   AST_COMMON_WAVE: assert property (@(posedge clk) disable iff (sys_rst)
      ctrl_q.common_waveform_mode |=> (wg_prev_q[1] == $past(tc.wg[0])))
      else $error("Common mode does not feed channel A");
   AST_MASKED_EVENT: assert property (@(posedge clk) disable iff (sys_rst)
      (prot_on && (|(fault_events & fault_event_mask_bits_q))) |=> fault_flag_q && fault_active)
      else $error("Enabled event did not raise a fault");
   AST_FLAG_HOLDS: assert property (@(posedge clk) disable iff (sys_rst)
      (fault_flag_q && !flag_clear) |=> fault_flag_q)
      else $error("Fault flag cleared without a write of one");
   AST_DEBUG_IGNORED: assert property (@(posedge clk) disable iff (sys_rst)
      (fctrl_q.ignore_debug_break && ((fault_events & fault_event_mask_bits_q) == 8'h00)) |-> !fault_det)
      else $error("Ignored debug break caused a fault");
   AST_LATCHED_WAIT: assert property (@(posedge clk) disable iff (sys_rst)
      (fault_active && !fctrl_q.fault_restart_mode && fault_flag_q) |=> fault_active)
      else $error("Latched fault left while flag still set");
   AST_CBC_RESTORE: assert property (@(posedge clk) disable iff (sys_rst)
      (fault_active && fctrl_q.fault_restart_mode && !fault_det && tc.update) |=> !fault_active)
      else $error("Cycle-by-cycle fault did not restore on update");
   AST_CLEAR_OVERRIDE: assert property (@(posedge clk) disable iff (sys_rst)
      (fault_det && (fctrl_q.fault_action == ACT_CLEAR_OVERRIDE)) |=> (pin_override_enables_q == 8'h00))
      else $error("Override enables not cleared on fault");
   AST_UNDEFINED_ACTION: assert property (@(posedge clk) disable iff (sys_rst)
      (fctrl_q.fault_action == ACT_UNDEFINED) |-> !fault_det)
      else $error("Undefined action code raised a fault");
   AST_LOCK_BLOCKS: assert property (@(posedge clk) disable iff (sys_rst)
      (tc.update && tc.lock_update_flag && low_buffer_valid_q) |=> low_buffer_valid_q)
      else $error("Buffer transferred while update locked");
   AST_COUNT_DOWN: assert property (@(posedge clk) disable iff (sys_rst)
      ((dt_cnt_q[0] != 8'h00) && (wg_sel[0] == wg_prev_q[0])) |=> (dt_cnt_q[0] == $past(dt_cnt_q[0]) - 8'h01))
      else $error("Dead-time counter did not decrement");
   AST_PAIR_OFF: assert property (@(posedge clk) disable iff (sys_rst)
      (dt_cnt_q[0] != 8'h00) |-> (dt_pins[1:0] == 2'b00))
      else $error("Pair driven during dead time");
   AST_RISE_RELOAD: assert property (@(posedge clk) disable iff (sys_rst)
      (wg_sel[0] && !wg_prev_q[0]) |=> (dt_cnt_q[0] == $past(dt_low_q)))
      else $error("Rising edge did not reload low dead time");

endmodule : wdfe_top

`default_nettype wire

// ==== tb/wdfe_tc_model.sv ====
// Timer and port stand-in for the dead-time and fault extension.
// Assumes the bench drives waveforms and the lock flag on clk.
`timescale 1ns/1ps
`default_nettype none
module wdfe_tc_model
   import wdfe_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] wg,
   input wire logic lock,
   output logic [13:0] tc,
   output logic [15:0] port
);
   logic [2:0] cnt_q;
   // Update every eight cycles keeps buffer waits short
   always_ff @(posedge clk) begin
      cnt_q <= sys_rst ? 3'h0 : cnt_q + 3'h1;
   end
   assign tc = {wg, 8'h3c, cnt_q == 3'h7, lock};
   assign port = {8'h5a, 8'hff};
endmodule : wdfe_tc_model
`default_nettype wire

// ==== tb/waveform_deadtime_fault_extension_test.sv ====
// Self-checking bench for the dead-time and fault extension.
// Assumes the timer stand-in wdfe_tc_model and a 4 ns clock.
`timescale 1ns/1ps
`default_nettype none
module waveform_deadtime_fault_extension_test
   import wdfe_pkg::*;
;
   logic clk = 1'b0, sys_rst = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0;
   logic arv = 1'b0, rr = 1'b0, dbg = 1'b0, lock = 1'b0;
   logic [7:0] aw = 8'h00, ar = 8'h00, ev = 8'h00, po, pd;
   logic [31:0] wd = 32'h0, rdat;
   logic [3:0] wg = 4'h0;
   logic awr, wrd, bv, arr, rv, fa;
   logic [1:0] bresp, rresp;
   logic [13:0] tc;
   logic [15:0] port;
   int fail_count = 0;
   int check_count = 0;
   always #2 clk = ~clk;
   wdfe_tc_model tcm (.clk(clk), .sys_rst(sys_rst), .wg(wg), .lock(lock), .tc(tc), .port(port));
   wdfe_top dut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .tc(tc), .port(port),
      .fault_events(ev), .debug_break(dbg), .pin_out(po), .pin_dir(pd), .fault_active(fa));
   task automatic complete_run;
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Ready is sampled at the falling edge, stable until the taking edge
   task automatic axi(input logic w, input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
      int n;
      logic ta, tw, te;
      if (w) begin
         aw <= {idx, 2'h0};
         wd <= {24'h0, d};
         awv <= 1'b1;
         wv <= 1'b1;
         br <= 1'b1;
      end else begin
         ar <= {idx, 2'h0};
         arv <= 1'b1;
         rr <= 1'b1;
      end
      for (n = 0; n < 40; n++) begin
         @(negedge clk);
         ta = (awv && awr) || (arv && arr);
         tw = wv && wrd;
         te = w ? bv : rv;
         if (te && !w) chk(rdat, {24'h0, d});
         if (te) chk(32'(w ? bresp : rresp), 32'(er));
         @(posedge clk);
         if (ta) awv <= 1'b0;
         if (ta) arv <= 1'b0;
         if (tw) wv <= 1'b0;
         if (te) break;
      end
      br <= 1'b0;
      rr <= 1'b0;
      // One idle edge keeps the next call from re-raising bready or rready in this step
      @(posedge clk);
      if (n == 40) begin
         fail_count++;
         complete_run();
      end
   endtask : axi
   task automatic waitf(input logic e);
      int n;
      for (n = 0; n < 40 && fa !== e; n++) @(negedge clk);
      chk(32'(fa), 32'(e));
      if (n == 40) complete_run();
      @(posedge clk);
   endtask : waitf
   task automatic t_regs;
      axi(0, IDX_STATUS, 8'h00, RESP_OKAY);
      axi(0, 6'h05, 8'h00, RESP_SLVERR);
      axi(1, IDX_BOTH, 8'h05, RESP_OKAY);
      axi(0, IDX_DT_LOW, 8'h05, RESP_OKAY);
      axi(0, IDX_DT_HIGH, 8'h05, RESP_OKAY);
   endtask : t_regs
   task automatic t_buf;
      lock <= 1'b1;
      axi(1, IDX_BOTH_BUF, 8'h09, RESP_OKAY);
      repeat (12) @(posedge clk);
      axi(0, IDX_STATUS, 8'h03, RESP_OKAY);
      axi(0, IDX_DT_LOW, 8'h05, RESP_OKAY);
      lock <= 1'b0;
      repeat (12) @(posedge clk);
      axi(0, IDX_DT_HIGH, 8'h09, RESP_OKAY);
      axi(0, IDX_STATUS, 8'h00, RESP_OKAY);
   endtask : t_buf
   task automatic t_fault;
      axi(1, IDX_FCTRL, 8'h11, RESP_OKAY);
      axi(1, IDX_FMASK, 8'h80, RESP_OKAY);
      axi(1, IDX_OVEN, 8'hff, RESP_OKAY);
      dbg <= 1'b1;
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk(32'(fa), 32'h0);
      @(posedge clk);
      dbg <= 1'b0;
      ev <= 8'h80;
      waitf(1'b1);
      axi(0, IDX_OVEN, 8'h00, RESP_OKAY);
      axi(1, IDX_OVEN, 8'h0f, RESP_OKAY);
      axi(0, IDX_OVEN, 8'h00, RESP_OKAY);
      ev <= 8'h00;
      repeat (12) @(posedge clk);
      axi(0, IDX_STATUS, 8'h04, RESP_OKAY);
      axi(1, IDX_STATUS, 8'h04, RESP_OKAY);
      waitf(1'b0);
   endtask : t_fault
   // Pins stay off for n-1 cycles after a waveform edge, then show e
   task automatic t_edge(input logic [3:0] w, input int n, input logic [7:0] e);
      wg <= w;
      repeat (n) @(posedge clk);
      @(negedge clk);
      chk(32'(po), 32'h30);
      @(posedge clk);
      @(negedge clk);
      chk(32'(po), 32'(e));
      @(posedge clk);
   endtask : t_edge
   task automatic t_dead;
      axi(1, IDX_DT_HIGH, 8'h04, RESP_OKAY);
      axi(1, IDX_CTRL, 8'h13, RESP_OKAY);
      axi(1, IDX_OVEN, 8'h0f, RESP_OKAY);
      t_edge(4'h1, 10, 8'h35);
      t_edge(4'h0, 5, 8'h3a);
      axi(1, IDX_FCTRL, 8'h07, RESP_OKAY);
      dbg <= 1'b1;
      waitf(1'b1);
      @(negedge clk);
      chk(32'(pd), 32'hf0);
      @(posedge clk);
      dbg <= 1'b0;
      waitf(1'b0);
      @(negedge clk);
      chk(32'(pd), 32'hff);
      @(posedge clk);
      axi(1, IDX_FCTRL, 8'h02, RESP_OKAY);
      dbg <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk(32'(fa), 32'h0);
      @(posedge clk);
      dbg <= 1'b0;
      axi(1, IDX_CTRL, 8'h20, RESP_OKAY);
      axi(1, IDX_DT_HIGH, 8'ha0, RESP_OKAY);
      wg <= 4'h1;
      @(posedge clk);
      @(negedge clk);
      chk(32'(po), 32'haf);
   endtask : t_dead
   initial begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_buf();
      t_fault();
      t_dead();
      complete_run();
   end
endmodule : waveform_deadtime_fault_extension_test
`default_nettype wire
